// ==== eight_bit_timer_pwm_capture_tb.sv ====
// Self-checking bench for the eight-bit timer through its APB registers.
module eight_bit_timer_pwm_capture_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import timer8_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic ack = 1'b0;
  logic go = 1'b0;
  logic cap, pin, ovf, mci, e;
  logic [31:0] r, r1;
  int n_fail = 0;
  int checks = 0;
  int k;
  always #20 pclk = ~pclk;
  timer8 uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .capture_input_pin(cap), .overflow_service_ack(ack), .timer_output_pin(pin),
    .overflow_interrupt(ovf), .match_capture_interrupt(mci));
  pulse_src src (.pclk(pclk), .go(go), .width(8'h3c), .pin(cap));
  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t %s got %h", $time, m, got);
    end
  endtask
  // The request stands unchanged until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  task automatic pulse_ack();
    @(posedge pclk);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
  endtask
  task automatic wait_pin(output int n);
    logic p;
    n = 0;
    p = pin;
    do begin
      @(posedge pclk);
      n++;
    end while (pin === p && n < 100);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ctrl_offset, 0);
    chk(r, 32'h0, "ctrl after reset");
    apb(0, 12'h010, 0);
    chk({31'h0, e}, 32'h1, "unmapped read");
    apb(1, ref_offset, 32'h3);
    apb(1, ctrl_offset, 32'h18);
    wait_pin(k);
    wait_pin(k);
    chk(k, 32'h4, "interval period");
    apb(0, ctrl_offset, 0);
    chk({31'h0, r[1]}, 32'h1, "match pending");
    chk({31'h0, mci}, 32'h1, "match interrupt");
    apb(1, ctrl_offset, 32'h0a);
    pulse_ack();
    apb(0, ctrl_offset, 0);
    chk(r, 32'h0a, "match pending kept by service");
    apb(1, ctrl_offset, 32'h08);
    apb(0, ctrl_offset, 0);
    chk(r, 32'h08, "match pending cleared");
    apb(1, ref_offset, 32'h40);
    apb(1, ctrl_offset, 32'hb4);
    apb(0, count_offset, 0);
    chk({31'h0, r[7:0] < 8'h08}, 32'h1, "counter clear");
    k = 0;
    repeat (512) begin
      @(posedge pclk);
      if (pin === 1'b1) k++;
    end
    chk(k, 32'd128, "pwm high time");
    k = 0;
    while (ovf !== 1'b1 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, ovf}, 32'h1, "overflow interrupt");
    pulse_ack();
    apb(0, ctrl_offset, 0);
    chk({30'h0, r[5], r[0]}, 32'h0, "overflow cleared by service");
    chk({31'h0, ovf}, 32'h0, "overflow interrupt dropped");
    apb(1, ctrl_offset, 32'h58);
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(0, ref_offset, 0);
    r1 = r;
    apb(0, ctrl_offset, 0);
    chk({31'h0, r[1]}, 32'h1, "capture pending");
    apb(1, ctrl_offset, 32'h158);
    repeat (60) @(posedge pclk);
    apb(0, ref_offset, 0);
    chk({24'h0, r[7:0]}, {24'h0, r1[7:0] + 8'h3c}, "falling capture");
    chk({31'h0, mci}, 32'h1, "capture interrupt");
    give_verdict();
  end
  // The tests take under 2000 cycles, so this span is generous.
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("mismatch %0t watchdog expired", $time);
    give_verdict();
  end
endmodule

// ==== pulse_src.sv ====
// Behavioural pulse source that stands at the capture input pin.
module pulse_src (
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] width,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_q = 8'h00;
  initial pin = 1'b0;
  // pin reaches the timer as if routed with selection 00.
  // clean edges: one rise, then one fall width cycles later.
  always @(posedge pclk) begin
    if (go) begin
      pin <= 1'b1;
      left_q <= width - 8'h01;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end else begin
      pin <= 1'b0;
    end
  end
endmodule

// ==== timer8.sv ====
// Eight-bit timer with interval, PWM and capture modes behind an APB slave.
// Function
// RL1: Separate overflow and match/capture interrupt sources.
// RL2: Overflow cleared by service or software.
// RL3: Software clears match pending after service.
// RL4: Interval match toggles pin, interrupts, clears counter.
// RL5: Interval mode restarts from zero automatically.
// RL6: PWM counter free runs and wraps.
// RL7: PWM output low when reference not above count.
// RL8: PWM period equals 256 timer ticks.
// RL9: Software may leave interrupts unused in PWM.
// RL10: Capture edge loads counter into data register.
// RL11: Capture edge selectable rising or falling.
// RL12: Software routes capture pin via port control.
// RL13: Capture mode raises overflow and capture interrupts.
// RL14: Data register read returns captured value.
// RL15: Reset clears control register to zero.
// RL16: Writing control bit 5 clears counter.
// RL17: Control bit 3 enables match/capture interrupt.
// RL18: Control bit 1 shows match pending.
// RL19: Counter increments on each prescaled tick.
// RL20: Capture mode counter free runs and wraps.
//
// The implementer's own choices: the address map and the APB register port.
module timer8 (
  input wire logic pclk,
  input wire logic presetn,
  input wire timer8_pkg::apb_req_t apb_req,
  output timer8_pkg::apb_rsp_t apb_rsp,
  input wire logic capture_input_pin,
  input wire logic overflow_service_ack,
  output logic timer_output_pin,
  output logic overflow_interrupt,
  output logic match_capture_interrupt
);
  import timer8_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] ref_q;
  logic [7:0] count_q;
  logic [7:0] prescale_q;
  logic [7:0] div_q;
  logic [1:0] edge_sel_q;
  logic cap_prev_q;
  logic out_q;
  logic ovpend_q;
  logic mcpend_q;
  logic ovirq_q;
  logic mcirq_q;
  apb_rsp_t rsp_q;

  timer_mode_t mode;
  logic wr_en;
  logic rd_en;
  logic tick;
  logic match;
  logic wrap;
  logic cap_edge;
  logic ctrl_wr;
  logic [31:0] rdata;

  assign mode = timer_mode_t'(ctrl_q[mode_lo +: 2]);
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
  assign ctrl_wr = wr_en && apb_req.paddr == ctrl_offset;
  // Match and wrap are qualified by the tick so that a slow prescaler
  // does not repeat an event for every clock that the count stands still.
  assign match = tick && count_q == ref_q;
  assign wrap = tick && count_q == 8'hff;

  // Prescaler: a tick every prescale_q + 1 clocks; zero selects the undivided clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign tick = ctrl_q[run_bit] && div_q >= prescale_q;

  // RL11: edge select
  assign cap_edge = edge_sel_q[0] ? (cap_prev_q & ~capture_input_pin)
                                  : (~cap_prev_q & capture_input_pin);

  // The previous sample resets low, the idle level of the capture source,
  // so that leaving reset never looks like a rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev_q <= 1'b0;
    end else begin
      cap_prev_q <= capture_input_pin;
    end
  end

  // Counter; the clear strobe wins over counting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= count_reset;
    // RL16: counter clear strobe
    end else if (ctrl_wr && apb_req.pwdata[clr_bit]) begin
      count_q <= 8'h00;
    // RL4: interval match clears
    end else if (mode == mode_interval && match) begin
      // RL5: counting resumes from zero
      count_q <= 8'h00;
    // RL19: increment per tick
    end else if (tick) begin
      // RL6: free run wraps in PWM; RL20: and in capture
      count_q <= count_q + 8'h01;
    end
  end

  // Output pin behaviour per mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (mode == mode_interval && match) begin
      // RL4: toggle on match
      out_q <= ~out_q;
    end else if (mode == mode_pwm) begin
      // RL7: PWM compare; RL8: full 256-count period
      out_q <= ref_q > count_q;
    end
  end

  // Reference/data register; capture loads it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= ref_reset;
    // RL10: capture load
    end else if (mode == mode_capture && cap_edge) begin
      ref_q <= count_q;
    end else if (wr_en && apb_req.paddr == ref_offset) begin
      ref_q <= apb_req.pwdata[7:0];
    end
  end

  // Control register; pending bits are kept apart so hardware sets win.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RL15: reset clears control
      ctrl_q <= ctrl_reset;
      prescale_q <= prescale_reset;
      edge_sel_q <= edge_sel_reset;
    end else if (ctrl_wr) begin
      // Bit 5 is never stored, so the clear strobe always reads back as zero.
      ctrl_q <= {apb_req.pwdata[7:6], 1'b0, apb_req.pwdata[4:2], 2'b00};
      edge_sel_q <= apb_req.pwdata[9:8];
    end else if (wr_en && apb_req.paddr == prescale_offset) begin
      prescale_q <= apb_req.pwdata[7:0];
    end
  end

  // RL1: two pending sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovpend_q <= 1'b0;
      mcpend_q <= 1'b0;
    end else begin
      // RL13: overflow sets in every mode
      if (wrap) begin
        ovpend_q <= 1'b1;
      // RL2: cleared by service or a zero write
      end else if (overflow_service_ack || (ctrl_wr && !apb_req.pwdata[ovpend_bit])) begin
        ovpend_q <= 1'b0;
      end
      // RL13: capture sets pending; RL4: match sets it
      if ((mode == mode_capture && cap_edge) || (mode != mode_capture && match)) begin
        mcpend_q <= 1'b1;
      // RL3: software writes zero to clear
      end else if (ctrl_wr && !apb_req.pwdata[mcpend_bit]) begin
        mcpend_q <= 1'b0;
      end
    end
  end

  // Interrupt lines follow pending bits gated by enables.
  // They trail the pending bits by one clock; this keeps every
  // top-level output straight from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovirq_q <= 1'b0;
      mcirq_q <= 1'b0;
    end else begin
      ovirq_q <= ovpend_q & ctrl_q[ovie_bit];
      // RL17: enable gate
      mcirq_q <= mcpend_q & ctrl_q[mcie_bit];
    end
  end

  // RL14: data readback; RL18: pending visible in bit 1
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (apb_req.paddr)
      ctrl_offset: rdata = {22'h000000, edge_sel_q, ctrl_q[7:2], mcpend_q, ovpend_q};
      ref_offset: rdata = {24'h000000, ref_q};
      count_offset: rdata = {24'h000000, count_q};
      prescale_offset: rdata = {24'h000000, prescale_q};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: pready rises in the first access cycle, registered.
  // Registering the answer costs no wait state, because it is launched
  // at the end of the setup cycle and stands through the access cycle.
  // A limitation: read data are taken from the setup cycle, so a capture
  // in that very cycle shows up only on the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready <= apb_req.psel & ~apb_req.penable;
      rsp_q.pslverr <= apb_req.psel & ~apb_req.penable & apb_req.paddr != ctrl_offset
                       & apb_req.paddr != ref_offset & apb_req.paddr != count_offset
                       & apb_req.paddr != prescale_offset;
      rsp_q.prdata <= (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) ? rdata : 32'h0;
    end
  end

  assign apb_rsp = rsp_q;
  assign timer_output_pin = out_q;
  assign overflow_interrupt = ovirq_q;
  assign match_capture_interrupt = mcirq_q;

  // Counter and output behaviour per mode. A control write in the same cycle
  // is left out of the antecedents of the |=> checks, since it may change mode or clear.
  a_interval_clear: assert property (@(posedge pclk) disable iff (!presetn)  // RL4
    mode == mode_interval && match && !ctrl_wr |=> count_q == 8'h00 && out_q != $past(out_q))
    else $error("interval match did not clear and toggle");
  a_pwm_level: assert property (@(posedge pclk) disable iff (!presetn)  // RL7
    mode == mode_pwm && $past(mode == mode_pwm) |-> out_q == ($past(ref_q) > $past(count_q)))
    else $error("pwm output level wrong");
  a_pwm_wrap: assert property (@(posedge pclk) disable iff (!presetn)  // RL6
    mode == mode_pwm && wrap && !ctrl_wr |=> count_q == 8'h00 && ovpend_q)
    else $error("pwm wrap wrong");
  a_pwm_match_run: assert property (@(posedge pclk) disable iff (!presetn)  // RL6
    mode == mode_pwm && match && count_q != 8'hff && !ctrl_wr |=> count_q == $past(count_q) + 8'h01)
    else $error("pwm match disturbed the counter");

  // Capture path.
  a_capture_load: assert property (@(posedge pclk) disable iff (!presetn)  // RL10
    mode == mode_capture && cap_edge |=> ref_q == $past(count_q) && mcpend_q)
    else $error("capture load missing");
  a_capture_run: assert property (@(posedge pclk) disable iff (!presetn)  // RL20
    mode == mode_capture && cap_edge && tick && !ctrl_wr |=> count_q == $past(count_q) + 8'h01)
    else $error("capture disturbed the counter");
  a_capture_ovf: assert property (@(posedge pclk) disable iff (!presetn)  // RL13
    mode == mode_capture && wrap |=> ovpend_q)
    else $error("capture mode overflow not pending");

  // Control, pending bits and interrupt lines.
  a_clear_strobe: assert property (@(posedge pclk) disable iff (!presetn)  // RL16
    ctrl_wr && apb_req.pwdata[clr_bit] |=> count_q == 8'h00)
    else $error("clear strobe ignored");
  a_mc_enable: assert property (@(posedge pclk) disable iff (!presetn)  // RL17
    mcpend_q && ctrl_q[mcie_bit] |=> match_capture_interrupt)
    else $error("match interrupt not raised");
  a_mc_gate: assert property (@(posedge pclk) disable iff (!presetn)  // RL17
    !ctrl_q[mcie_bit] |=> !match_capture_interrupt)
    else $error("match interrupt raised while disabled");
  a_mc_sticky: assert property (@(posedge pclk) disable iff (!presetn)  // RL3
    mcpend_q && !ctrl_wr |=> mcpend_q)
    else $error("match pending lost without software");
  a_ov_service: assert property (@(posedge pclk) disable iff (!presetn)  // RL2
    overflow_service_ack && !wrap |=> !ovpend_q)
    else $error("overflow pending not cleared by service");
  a_ov_sticky: assert property (@(posedge pclk) disable iff (!presetn)  // RL2
    ovpend_q && !overflow_service_ack && !ctrl_wr |=> ovpend_q)
    else $error("overflow pending lost without clear");
  a_ov_enable: assert property (@(posedge pclk) disable iff (!presetn)  // RL1
    ovpend_q && ctrl_q[ovie_bit] |=> overflow_interrupt)
    else $error("overflow interrupt not raised");
  a_ctrl_reset: assert property (@(posedge pclk)  // RL15
    $rose(presetn) |-> ctrl_q == ctrl_reset && !mcpend_q && !ovpend_q)
    else $error("control not cleared by reset");
  a_tick_count: assert property (@(posedge pclk) disable iff (!presetn)  // RL19
    tick && !ctrl_wr && !(mode == mode_interval && match) |=> count_q == $past(count_q) + 8'h01)
    else $error("counter did not advance");

  // Register reads: the answer stands in the access cycle.
  a_pend_read: assert property (@(posedge pclk) disable iff (!presetn)  // RL18
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == ctrl_offset
    |=> apb_rsp.prdata[mcpend_bit] == $past(mcpend_q))
    else $error("match pending not visible on read");
  a_ref_read: assert property (@(posedge pclk) disable iff (!presetn)  // RL14
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == ref_offset
    |=> apb_rsp.pready && apb_rsp.prdata[7:0] == $past(ref_q))
    else $error("data register read wrong");

  c_interval: cover property (@(posedge pclk) mode == mode_interval && match);
  c_pwm_wrap: cover property (@(posedge pclk) mode == mode_pwm && wrap);
  c_capture: cover property (@(posedge pclk) mode == mode_capture && cap_edge);
  c_falling_capture: cover property (@(posedge pclk) mode == mode_capture && cap_edge && edge_sel_q[0]);
  c_ov_service: cover property (@(posedge pclk) overflow_service_ack && ovpend_q);
endmodule

// ==== timer8_pkg.sv ====
// Package with register map, field positions and types for the 8-bit timer.
package timer8_pkg;
  localparam logic [11:0] ctrl_offset = 12'h000;
  localparam logic [11:0] ref_offset = 12'h004;
  localparam logic [11:0] count_offset = 12'h008;
  localparam logic [11:0] prescale_offset = 12'h00c;
  localparam int mode_lo = 6;
  localparam int clr_bit = 5;
  localparam int run_bit = 4;
  localparam int mcie_bit = 3;
  localparam int ovie_bit = 2;
  localparam int mcpend_bit = 1;
  localparam int ovpend_bit = 0;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] ref_reset = 8'hff;
  localparam logic [7:0] count_reset = 8'h00;
  localparam logic [7:0] prescale_reset = 8'h00;
  localparam logic [1:0] edge_sel_reset = 2'h0;

  typedef enum logic [1:0] {
    mode_interval,
    mode_capture,
    mode_pwm,
    mode_spare
  } timer_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
endpackage
